// File: bench/i2cis_properties.sv
`timescale 1ns/1ps
module i2cis_properties
  import i2cis_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic controller_enable_reg,
  input wire logic [11:0] interrupt_mask_reg,
  input wire logic [15:0] abort_reason,
  input wire i2cis_event_type events,
  input wire i2cis_clear_type clears,
  input wire logic [15:0] i2c_masked_interrupt_status,
  input wire logic [15:0] abort_source_reg,
  input wire logic [11:0] raw_status,
  input wire logic tx_fifo_flush,
  input wire logic scl_hold_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // enabled, no clear strobe
  wire logic calm = controller_enable_reg && clears == '0;
  property p_up;
    i2c_masked_interrupt_status ==
      {4'h0, raw_status & $past(interrupt_mask_reg)};
  endproperty
  property p_st; events.start_seen && calm ##1 calm |=> raw_status[10];
  endproperty
  property p_gc; events.gen_call_acked && calm ##1 calm |=> raw_status[11];
  endproperty
  property p_act; raw_status[8] && $past(calm) |=> raw_status[8];
  endproperty
  property p_acl; clears.activity_clear_reg && !events.activity
    ##1 !events.activity |=> !raw_status[8]; endproperty
  property p_ab; events.tx_abort |=>
    abort_source_reg == $past(abort_reason); endproperty
  property p_fl; events.tx_abort |=> tx_fifo_flush; endproperty
  property p_rq; events.read_request |-> ##[1:2] scl_hold_low; endproperty
  a_up: assert property (p_up) else $error("bad status");
  a_st: assert property (p_st) else $error("start flag");
  a_gc: assert property (p_gc) else $error("general call");
  a_act: assert property (p_act) else $error("activity lost");
  a_acl: assert property (p_acl) else $error("activity kept");
  a_ab: assert property (p_ab) else $error("abort source");
  a_fl: assert property (p_fl) else $error("no flush");
  a_rq: assert property (p_rq) else $error("scl not held");
  c_ab: cover property (events.tx_abort);
  c_rq: cover property (events.read_request);
  c_cl: cover property (clears.combined_interrupt_clear_reg);
endmodule : i2cis_properties
bind i2cis_status i2cis_properties chk (
  .clk(clk), .arst_n(arst_n),
  .controller_enable_reg(controller_enable_reg),
  .interrupt_mask_reg(interrupt_mask_reg),
  .abort_reason(abort_reason), .events(events), .clears(clears),
  .i2c_masked_interrupt_status(i2c_masked_interrupt_status),
  .abort_source_reg(abort_source_reg), .raw_status(raw_status),
  .tx_fifo_flush(tx_fifo_flush), .scl_hold_low(scl_hold_low)
);

// File: bench/i2cis_remote.sv
`timescale 1ns/1ps
module i2cis_remote
  import i2cis_pkg::*;
(
  input wire logic clk,
  output i2cis_event_type events
);
  initial events = '0;
  // a bus condition lasts one controller cycle
  task automatic bus_event(input i2cis_event_type e);
    @(negedge clk) events = e;
    @(negedge clk) events = '0;
  endtask : bus_event
endmodule : i2cis_remote

// File: bench/test_i2c_interrupt_status.sv
`timescale 1ns/1ps
module test_i2c_interrupt_status;
  import i2cis_pkg::*;
  logic clk = 0, arst_n = 0, controller_enable_reg = 1;
  logic internal_enable_signal = 1, engines_active = 0;
  logic data_cmd_write = 0, data_cmd_read = 0;
  logic [11:0] interrupt_mask_reg = 12'hF7F;
  logic [5:0] tx_threshold_reg = 6'h02, rx_threshold_reg = 6'h04;
  logic [5:0] tx_level = 6'h0A, rx_level = 6'h00;
  logic [15:0] abort_reason = 16'h00A5;
  i2cis_event_type events;
  i2cis_clear_type clears = '0;
  logic [15:0] i2c_masked_interrupt_status, abort_source_reg, read_data;
  logic [11:0] raw_status;
  logic tx_fifo_flush, rx_fifo_flush, rx_byte_discard, scl_hold_low;
  int error_cnt = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  i2cis_remote remote (.clk(clk), .events(events));
  i2cis_status dut (
    .clk(clk), .arst_n(arst_n),
    .controller_enable_reg(controller_enable_reg),
    .internal_enable_signal(internal_enable_signal),
    .engines_active(engines_active),
    .interrupt_mask_reg(interrupt_mask_reg),
    .tx_threshold_reg(tx_threshold_reg),
    .rx_threshold_reg(rx_threshold_reg),
    .tx_level(tx_level), .rx_level(rx_level),
    .data_cmd_write(data_cmd_write), .data_cmd_read(data_cmd_read),
    .abort_reason(abort_reason), .events(events), .clears(clears),
    .i2c_masked_interrupt_status(i2c_masked_interrupt_status),
    .abort_source_reg(abort_source_reg), .raw_status(raw_status),
    .tx_fifo_flush(tx_fifo_flush), .rx_fifo_flush(rx_fifo_flush),
    .rx_byte_discard(rx_byte_discard), .scl_hold_low(scl_hold_low),
    .read_data(read_data)
  );
  task automatic ck(string n, logic [15:0] x, logic [15:0] g);
    samples_checked++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : ck
  task automatic rk(string n, logic [11:0] x);
    ck(n, {4'h0, x}, {4'h0, raw_status});
  endtask : rk
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic clr(i2cis_clear_type c);
    @(negedge clk) clears = c;
    @(negedge clk) clears = '0;
    step(1);
  endtask : clr
  task automatic t_sticky;
    logic [11:0] x = 12'h000;
    for (int i = 3; i < 8; i++) begin
      remote.bus_event(8'h01 << i);
      step(1);
      x = x | (12'h001 << (i + 4));
      rk("flag", x);
    end
    step(5);
    ck("masked", 16'h0F00, i2c_masked_interrupt_status);
    ck("read", 16'h0F00, read_data);
    clr(5'h08);
    rk("actclr", 12'hE80);
    clr(5'h04);
    rk("allclr", 12'h000);
  endtask : t_sticky
  task automatic t_disable;
    remote.bus_event(8'h90);
    tx_level = 6'h20;
    data_cmd_write = 1;
    step(1);
    rk("gcset", 12'h900);
    data_cmd_write = 0;
    controller_enable_reg = 0;
    engines_active = 1;
    step(3);
    rk("disabled", 12'h018);
    ck("flushes", 16'h0003, {14'h0, rx_fifo_flush, tx_fifo_flush});
    engines_active = 0;
    step(2);
    rk("idle", 12'h008);
    internal_enable_signal = 0;
    step(2);
    rk("off", 12'h000);
    controller_enable_reg = 1;
    internal_enable_signal = 1;
    tx_level = 6'h0A;
    step(2);
  endtask : t_disable
  task automatic t_abort;
    remote.bus_event(8'h04);
    step(1);
    rk("abort", 12'h050);
    ck("source", 16'h00A5, abort_source_reg);
    clr(5'h02);
    ck("flush", 16'h0000, {raw_status, 3'h0, tx_fifo_flush});
  endtask : t_abort
  task automatic t_rdreq;
    remote.bus_event(8'h02);
    step(1);
    ck("hold", 16'h0003, {14'h0, raw_status[5], scl_hold_low});
    data_cmd_write = 1;
    step(1);
    data_cmd_write = 0;
    clr(5'h01);
    ck("served", 16'h0000, {14'h0, raw_status[5], scl_hold_low});
  endtask : t_rdreq
  task automatic t_levels;
    tx_level = 6'h02;
    rx_level = 6'h04;
    step(2);
    rk("at", 12'h014);
    tx_level = 6'h03;
    rx_level = 6'h00;
    data_cmd_read = 1;
    step(1);
    data_cmd_read = 0;
    step(2);
    rk("under", 12'h001);
    rx_level = 6'h20;
    remote.bus_event(8'h01);
    ck("discard", 16'h0001, {15'h0, rx_byte_discard});
    step(1);
    rk("over", 12'h007);
  endtask : t_levels
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    step(4);
    arst_n = 1;
    step(1);
    ck("reset", MASKED_STAT_RESET, i2c_masked_interrupt_status);
    t_sticky;
    t_disable;
    t_abort;
    t_rdreq;
    t_levels;
    report_and_stop;
  end
  initial begin
    step(500);
    error_cnt++;
    report_and_stop;
  end
endmodule : test_i2c_interrupt_status

// File: verilog/i2cis_pkg.sv
package i2cis_pkg;
  localparam logic [31:0] MASKED_STAT_ADDR = 32'h5000132C;
  localparam logic [15:0] MASKED_STAT_RESET = 16'h0000;
  localparam logic [11:0] MASK_RESET = 12'h8FF;
  localparam int BIT_RX_UNDER = 0;
  localparam int BIT_RX_OVER = 1;
  localparam int BIT_RX_FULL = 2;
  localparam int BIT_TX_OVER = 3;
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_RD_REQ = 5;
  localparam int BIT_TX_ABRT = 6;
  localparam int BIT_TX_DONE = 7;
  localparam int BIT_ACTIVITY = 8;
  localparam int BIT_STOP = 9;
  localparam int BIT_START = 10;
  localparam int BIT_GEN_CALL = 11;
  localparam int FIFO_DEPTH = 32;
  localparam int LEVEL_W = 6;

  // one-cycle pulses from the bus engine, same clock
  typedef struct packed {
    logic gen_call_acked;
    logic start_seen;
    logic stop_seen;
    logic activity;
    logic slave_tx_nack;
    logic tx_abort;
    logic read_request;
    logic rx_byte;
  } i2cis_event_type;

  // one-cycle read strobes of clear-on-read registers
  typedef struct packed {
    logic general_call_clear_reg;
    logic activity_clear_reg;
    logic combined_interrupt_clear_reg;
    logic abort_clear_reg;
    logic read_request_clear_reg;
  } i2cis_clear_type;
endpackage : i2cis_pkg

// File: verilog/i2cis_status.sv
`timescale 1ns/1ps
// Operation
// - general call flag after acked call address
// - general call clears on disable or read
// - flag START or repeated START detected
// - flag STOP detected
// - activity flag sticky after idle
// - activity cleared by disable, reads, reset
// - slave transmit nack sets transmit done
// - transmit abort flag, source recorded
// - abort flushes tx fifo until cleared
// - read request flag holds scl low
// - tx low water at or below threshold
// - disabled: tx flushed, low water follows activity
// - overflow on write to full tx fifo
// - tx overflow holds until internal enable falls or the combined clear
// - rx high water at or above threshold
// - rx overflow on byte into full fifo
// - rx underflow on read of empty fifo
// - status equals raw gated by mask
module i2cis_status
  import i2cis_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic controller_enable_reg,
  input wire logic internal_enable_signal,
  input wire logic engines_active,
  input wire logic [11:0] interrupt_mask_reg,
  input wire logic [LEVEL_W-1:0] tx_threshold_reg,
  input wire logic [LEVEL_W-1:0] rx_threshold_reg,
  input wire logic [LEVEL_W-1:0] tx_level,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic data_cmd_write,
  input wire logic data_cmd_read,
  input wire logic [15:0] abort_reason,
  input wire i2cis_event_type events,
  input wire i2cis_clear_type clears,
  output logic [15:0] i2c_masked_interrupt_status,
  output logic [15:0] abort_source_reg,
  output logic [11:0] raw_status,
  output logic tx_fifo_flush,
  output logic rx_fifo_flush,
  output logic rx_byte_discard,
  output logic scl_hold_low,
  output logic [15:0] read_data
);
  // flag state, one register per raw status bit except tx empty and rx full
  logic gen_call_q;
  logic start_q;
  logic stop_q;
  logic act_q;
  logic done_q;
  logic abrt_q;
  logic rdreq_q;
  logic txover_q;
  logic rxover_q;
  logic rxunder_q;
  logic [11:0] raw_d;
  logic [11:0] masked_d;
  logic clr_all;
  logic quiet_clr;
  logic gen_call_clr;
  logic act_clr;
  logic abrt_clr;
  logic rdreq_clr;
  logic drain_clr;
  logic tx_full;
  logic rx_full;
  logic rx_empty;
  logic tx_low_water;
  logic rx_high_water;

  // full means DEPTH entries; DEPTH must fit in LEVEL_W bits
  function automatic logic level_full(input logic [LEVEL_W-1:0] level);
    level_full = level >= LEVEL_W'(DEPTH);
  endfunction : level_full

  assign clr_all = clears.combined_interrupt_clear_reg;
  // start, stop and done drop on the combined clear or on disable
  assign quiet_clr = clr_all || !controller_enable_reg;
  assign gen_call_clr = quiet_clr || clears.general_call_clear_reg;
  assign act_clr = quiet_clr || clears.activity_clear_reg;
  assign abrt_clr = clr_all || clears.abort_clear_reg;
  assign rdreq_clr = clr_all || clears.read_request_clear_reg;
  // overflow-style flags wait for the internal enable to fall or the combined clear
  assign drain_clr = clr_all || !internal_enable_signal;
  assign tx_full = level_full(tx_level);
  assign rx_full = level_full(rx_level);
  assign rx_empty = rx_level == '0;
  // a level equal to the threshold counts as low and as high water
  assign tx_low_water = tx_level <= tx_threshold_reg;
  assign rx_high_water = rx_level >= rx_threshold_reg;

  // set beats clear in every sticky flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_call_q <= 1'b0;
    end else if (events.gen_call_acked && controller_enable_reg) begin
      gen_call_q <= 1'b1;
    end else if (gen_call_clr) begin
      gen_call_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b0;
    end else if (events.start_seen) begin
      start_q <= 1'b1;
    end else if (quiet_clr) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_q <= 1'b0;
    end else if (events.stop_seen) begin
      stop_q <= 1'b1;
    end else if (quiet_clr) begin
      stop_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_q <= 1'b0;
    end else if (events.activity && controller_enable_reg) begin
      act_q <= 1'b1;
    end else if (act_clr) begin
      act_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else if (events.slave_tx_nack) begin
      done_q <= 1'b1;
    end else if (quiet_clr) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      abrt_q <= 1'b0;
    end else if (events.tx_abort) begin
      abrt_q <= 1'b1;
    end else if (abrt_clr) begin
      abrt_q <= 1'b0;
    end
  end

  // source is kept only while the abort flag stands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      abort_source_reg <= 16'h0000;
    end else if (events.tx_abort) begin
      abort_source_reg <= abort_reason;
    end else if (abrt_clr) begin
      abort_source_reg <= 16'h0000;
    end
  end

  // scl stays low until the processor reads the clear register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdreq_q <= 1'b0;
    end else if (events.read_request) begin
      rdreq_q <= 1'b1;
    end else if (rdreq_clr) begin
      rdreq_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txover_q <= 1'b0;
    end else if (data_cmd_write && tx_full) begin
      txover_q <= 1'b1;
    end else if (drain_clr) begin
      txover_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxover_q <= 1'b0;
    end else if (events.rx_byte && rx_full) begin
      rxover_q <= 1'b1;
    end else if (drain_clr) begin
      rxover_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxunder_q <= 1'b0;
    end else if (data_cmd_read && rx_empty) begin
      rxunder_q <= 1'b1;
    end else if (drain_clr) begin
      rxunder_q <= 1'b0;
    end
  end

  always_comb begin
    raw_d = 12'h000;
    raw_d[BIT_GEN_CALL] = gen_call_q;
    raw_d[BIT_START] = start_q;
    raw_d[BIT_STOP] = stop_q;
    raw_d[BIT_ACTIVITY] = act_q;
    raw_d[BIT_TX_DONE] = done_q;
    raw_d[BIT_TX_ABRT] = abrt_q;
    raw_d[BIT_RD_REQ] = rdreq_q;
    raw_d[BIT_TX_OVER] = txover_q;
    raw_d[BIT_RX_OVER] = rxover_q;
    raw_d[BIT_RX_UNDER] = rxunder_q;
    // an aborted fifo is flushed, so it reads as low water
    if (!controller_enable_reg) begin
      raw_d[BIT_TX_EMPTY] = engines_active;
    end else if (abrt_q) begin
      raw_d[BIT_TX_EMPTY] = 1'b1;
    end else begin
      raw_d[BIT_TX_EMPTY] = tx_low_water;
    end
    // a disabled receive fifo is held in reset and never full
    raw_d[BIT_RX_FULL] = controller_enable_reg && rx_high_water;
  end

  // each status bit is its raw bit gated by its own mask bit
  for (genvar b = 0; b < 12; b++) begin : g_mask
    assign masked_d[b] = raw_d[b] & interrupt_mask_reg[b];
  end

  // status is registered, one cycle behind the flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_status <= 12'h000;
    end else begin
      raw_status <= raw_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i2c_masked_interrupt_status <= MASKED_STAT_RESET;
    end else begin
      // reserved upper bits are tied low
      i2c_masked_interrupt_status <= {4'h0, masked_d};
    end
  end

  // flush starts in the abort cycle itself, before the flag shows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_fifo_flush <= 1'b0;
    end else begin
      tx_fifo_flush <= abrt_q || events.tx_abort
                       || !controller_enable_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_fifo_flush <= 1'b0;
    end else begin
      rx_fifo_flush <= !controller_enable_reg;
    end
  end

  // released in the very cycle the clear strobe is seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_hold_low <= 1'b0;
    end else begin
      scl_hold_low <= (rdreq_q || events.read_request)
                      && !clears.read_request_clear_reg;
    end
  end

  // byte is acknowledged on the bus but never written
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_byte_discard <= 1'b0;
    end else begin
      rx_byte_discard <= events.rx_byte && rx_full;
    end
  end

  // read port of status; no write port exists
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      read_data <= 16'h0000;
    end else begin
      read_data <= {4'h0, masked_d};
    end
  end
endmodule : i2cis_status
